// ---- logic/sysconf_top.sv ----
// Function
// - Straps decode: high strap low test, low strap low programming, else internal.
// - Both straps high: empty program memory picks programming, else internal run.
// - Strap pull-ups enabled only during reset while straps are sampled.
// - Internal run mode starts execution at address zero.
// - Programming mode starts execution in the boot ROM routine.
// - Configuration register is eight bits, bits 1 to 5 read/write, others read zero, cleared by reset.
// - Layout: half-rate, large slow, fast data, small slow, cpu clock enables.
// - Configuration contents survive every power mode change.
// - CPU clock pin floats when disabled, carries CPU clock when enabled.
// - Small package slow clock pin floats or drives per its enable.
// - Large package slow clock pin floats or drives per its enable.
// - Fast data bit gives zero wait states, otherwise one.
// - Half-rate pin drives CPU clock over two when enabled and cpu off.
// - Strap levels captured at reset into read-only status bits.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module sysconf_top
	import sysconf_pkg::*;
#(
	parameter int CPU_DIV = CPU_DIV_DEFAULT
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	input  wire logic        mode_strap_low_i,
	input  wire logic        mode_strap_high_i,
	output logic             strap_pullup_en_o,
	input  wire logic        program_memory_empty_i,
	input  wire logic        program_busy_i,
	input  wire logic        slow_clk_i,
	output logic             cpu_clock_pin_o,
	output logic             cpu_clock_pin_oe_o,
	output logic             half_rate_clock_pin_o,
	output logic             half_rate_clock_pin_oe_o,
	output logic             slow_clock_pin_small_o,
	output logic             slow_clock_pin_small_oe_o,
	output logic             slow_clock_pin_large_o,
	output logic             slow_clock_pin_large_oe_o,
	input  wire logic        ee_req_i,
	output logic             ee_ack_o,
	output logic             ee_wait_states_o,
	output logic             cpu_start_o,
	output logic [15:0]      cpu_start_addr_o,
	output logic             test_mode_o,
	output logic             in_system_programming_mode_o,
	output logic             internal_memory_run_mode_o
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]     cfg_q;
	logic [31:0]    prdata_q;
	logic           pslverr_q;
	logic [1:0]     captured_strap_bits;
	boot_state_type state_q;
	logic           start_q;
	logic [15:0]    start_addr_q;
	logic           ee_busy_q;
	logic           ee_wait_q;
	logic           setup_phase;
	logic           access_phase;
	logic           wr_cfg;

	clk_ctl_if clk_ctl ();

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic is_mapped(input logic [11:0] addr);
		logic hit;
		hit = 1'b0;
		if (addr == CFG_OFFSET) begin
			hit = 1'b1;
		end else if (addr == STATUS_OFFSET) begin
			hit = 1'b1;
		end
		return hit;
	endfunction : is_mapped

	function automatic logic [31:0] read_word(
		input logic [11:0] addr,
		input logic [7:0]  cfg,
		input logic [1:0]  straps,
		input logic        busy
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (addr == CFG_OFFSET) begin
			w[7:0] = cfg;
		end else if (addr == STATUS_OFFSET) begin
			w[STAT_STRAP_LOW_BIT]  = straps[0];
			w[STAT_STRAP_HIGH_BIT] = straps[1];
			w[STAT_PGM_BUSY_BIT]   = busy;
		end
		return w;
	endfunction : read_word

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	assign setup_phase  = psel_i & ~penable_i;
	assign access_phase = psel_i & penable_i;
	assign pready_o     = access_phase;
	assign prdata_o     = prdata_q;
	assign pslverr_o    = pslverr_q & access_phase;
	assign wr_cfg       = access_phase & pwrite_i & ~pslverr_q
	                      & (paddr_i == CFG_OFFSET) & pstrb_i[0];

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup_phase) begin
			prdata_q  <= pwrite_i ? 32'h0000_0000
			             : read_word(paddr_i, cfg_q, captured_strap_bits, program_busy_i);
			pslverr_q <= ~is_mapped(paddr_i) | (pwrite_i & (paddr_i == STATUS_OFFSET));
		end
	end

	// ------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------
	// Cleared at reset
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cfg_q <= CFG_RESET;
		end else if (wr_cfg) begin
			cfg_q <= pwdata_i[7:0] & CFG_WRITABLE_MASK;
		end
	end

	assign clk_ctl.cpu_oe        = cfg_q[CFG_CPU_CLK_BIT];
	assign clk_ctl.half_en       = cfg_q[CFG_HALF_RATE_BIT];
	assign clk_ctl.slow_small_en = cfg_q[CFG_SLOW_SMALL_BIT];
	assign clk_ctl.slow_large_en = cfg_q[CFG_SLOW_LARGE_BIT];

	// ------------------------------------------------------------
	// Strap capture and clock pins
	// ------------------------------------------------------------
	strap_capture u_strap (
		.clk_i        (clk_i),
		.rstn_i       (rstn_i),
		.strap_low_i  (mode_strap_low_i),
		.strap_high_i (mode_strap_high_i),
		.pullup_en_o  (strap_pullup_en_o),
		.captured_o   (captured_strap_bits)
	);

	clock_pins #(
		.CPU_DIV (CPU_DIV)
	) u_clk (
		.clk_i           (clk_i),
		.rstn_i          (rstn_i),
		.slow_clk_i      (slow_clk_i),
		.ctl             (clk_ctl.pins),
		.cpu_pin_o       (cpu_clock_pin_o),
		.cpu_oe_o        (cpu_clock_pin_oe_o),
		.half_pin_o      (half_rate_clock_pin_o),
		.half_oe_o       (half_rate_clock_pin_oe_o),
		.slow_small_o    (slow_clock_pin_small_o),
		.slow_small_oe_o (slow_clock_pin_small_oe_o),
		.slow_large_o    (slow_clock_pin_large_o),
		.slow_large_oe_o (slow_clock_pin_large_oe_o)
	);

	// ------------------------------------------------------------
	// Boot sequence
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_q <= ST_RESET_HOLD;
		end else begin
			case (state_q)
				ST_RESET_HOLD: begin
					state_q <= ST_DECIDE;
				end
				ST_DECIDE: begin
					if (!captured_strap_bits[1]) begin
						state_q <= ST_RUN_TEST;
					end else if (!captured_strap_bits[0]) begin
						state_q <= ST_RUN_ISP;
					end else if (program_memory_empty_i) begin
						state_q <= ST_RUN_ISP;
					end else begin
						state_q <= ST_RUN_IRE;
					end
				end
				default: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			start_q      <= 1'b0;
			start_addr_q <= IRE_START_ADDR;
		end else begin
			start_q <= (state_q == ST_DECIDE) & captured_strap_bits[1];
			if (state_q == ST_DECIDE) begin
				if (captured_strap_bits == STRAP_RESET && !program_memory_empty_i) begin
					start_addr_q <= IRE_START_ADDR;
				end else begin
					start_addr_q <= BOOT_ROM_ADDR;
				end
			end
		end
	end

	assign cpu_start_o                  = start_q;
	assign cpu_start_addr_o             = start_addr_q;
	assign test_mode_o                  = (state_q == ST_RUN_TEST);
	assign in_system_programming_mode_o = (state_q == ST_RUN_ISP);
	assign internal_memory_run_mode_o   = (state_q == ST_RUN_IRE);

	// ------------------------------------------------------------
	// Data memory wait states
	// ------------------------------------------------------------
	// Wait state select
	assign ee_wait_states_o = cfg_q[CFG_FAST_EE_BIT] ? EE_WAIT_FAST : EE_WAIT_SLOW;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ee_busy_q <= 1'b0;
			ee_wait_q <= 1'b0;
		end else if (!ee_busy_q) begin
			ee_busy_q <= ee_req_i;
			ee_wait_q <= ee_wait_states_o;
		end else if (ee_wait_q) begin
			ee_wait_q <= 1'b0;
		end else begin
			ee_busy_q <= 1'b0;
		end
	end

	assign ee_ack_o = ee_busy_q & ~ee_wait_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	cfg_reset_clear_a: assert property (
		@(posedge clk_i) disable iff (1'b0) !rstn_i |=> (cfg_q == CFG_RESET))
		else $error("configuration not cleared by reset");

	reserved_bits_zero_a: assert property (
		(cfg_q & ~CFG_WRITABLE_MASK) == 8'h00)
		else $error("reserved configuration bit set");

	cfg_retained_a: assert property (
		!wr_cfg && $past(rstn_i) |=> $stable(cfg_q))
		else $error("configuration changed without a write");

	cpu_pin_follow_a: assert property (
		wr_cfg |=> (cpu_clock_pin_oe_o == $past(pwdata_i[CFG_CPU_CLK_BIT])))
		else $error("cpu clock pin enable does not follow write");

	half_rate_gate_a: assert property (
		half_rate_clock_pin_oe_o |-> cfg_q[CFG_HALF_RATE_BIT] && !cfg_q[CFG_CPU_CLK_BIT])
		else $error("half rate pin driven wrongly");

	half_rate_blocked_a: assert property (
		cfg_q[CFG_HALF_RATE_BIT] && cfg_q[CFG_CPU_CLK_BIT] |-> !half_rate_clock_pin_oe_o)
		else $error("half rate pin driven with cpu clock on");

	pullup_release_a: assert property (
		@(posedge clk_i) disable iff (1'b0) rstn_i && $past(rstn_i) |-> !strap_pullup_en_o)
		else $error("strap pull-up on outside reset");

	straps_held_a: assert property (
		$past(rstn_i) |-> $stable(captured_strap_bits))
		else $error("captured straps changed after reset");

	test_decode_a: assert property (
		state_q == ST_DECIDE && !captured_strap_bits[1] |=> test_mode_o && !cpu_start_o)
		else $error("test mode not selected");

	empty_isp_a: assert property (
		state_q == ST_DECIDE && captured_strap_bits == STRAP_RESET && program_memory_empty_i
		|=> in_system_programming_mode_o)
		else $error("empty memory did not select programming");

	ire_start_a: assert property (
		state_q == ST_DECIDE && captured_strap_bits == STRAP_RESET && !program_memory_empty_i
		|=> cpu_start_o && cpu_start_addr_o == IRE_START_ADDR ##1 !cpu_start_o)
		else $error("internal run start wrong");

	isp_start_a: assert property (
		cpu_start_o && in_system_programming_mode_o |-> cpu_start_addr_o == BOOT_ROM_ADDR)
		else $error("programming start address wrong");

	ee_wait_a: assert property (
		!ee_busy_q && ee_req_i && !cfg_q[CFG_FAST_EE_BIT] |=> !ee_ack_o ##1 ee_ack_o)
		else $error("slow data access ack timing wrong");

	ee_fast_a: assert property (
		!ee_busy_q && ee_req_i && cfg_q[CFG_FAST_EE_BIT] |=> ee_ack_o)
		else $error("fast data access ack timing wrong");

	cov_ire_c:  cover property (cpu_start_o && internal_memory_run_mode_o);
	cov_isp_c:  cover property (cpu_start_o && in_system_programming_mode_o);
	cov_test_c: cover property ($rose(test_mode_o));
	cov_half_c: cover property (half_rate_clock_pin_oe_o ##1 wr_cfg ##1 cpu_clock_pin_oe_o);

endmodule : sysconf_top

`default_nettype wire

// ---- logic/sysconf_pkg.sv ----
package sysconf_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int          ADDR_W             = 12;
	localparam logic [11:0] CFG_OFFSET         = 12'h000;
	localparam logic [11:0] STATUS_OFFSET      = 12'h004;

	// ------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------
	localparam int          CFG_CPU_CLK_BIT    = 1;
	localparam int          CFG_SLOW_SMALL_BIT = 2;
	localparam int          CFG_FAST_EE_BIT    = 3;
	localparam int          CFG_SLOW_LARGE_BIT = 4;
	localparam int          CFG_HALF_RATE_BIT  = 5;
	localparam logic [7:0]  CFG_RESET          = 8'h00;
	localparam logic [7:0]  CFG_WRITABLE_MASK  = 8'h3E;

	// ------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------
	localparam int          STAT_STRAP_LOW_BIT = 0;
	localparam int          STAT_STRAP_HIGH_BIT = 1;
	localparam int          STAT_PGM_BUSY_BIT  = 3;
	localparam logic [1:0]  STRAP_RESET        = 2'h3;

	// ------------------------------------------------------------
	// Boot addresses and wait states
	// ------------------------------------------------------------
	localparam logic [15:0] IRE_START_ADDR     = 16'h0000;
	localparam logic [15:0] BOOT_ROM_ADDR      = 16'hF000;
	localparam logic        EE_WAIT_FAST       = 1'b0;
	localparam logic        EE_WAIT_SLOW       = 1'b1;
	localparam int          CPU_DIV_DEFAULT    = 2;

	// ------------------------------------------------------------
	// Boot sequence states
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_RESET_HOLD = 5'h01,
		ST_DECIDE     = 5'h02,
		ST_RUN_IRE    = 5'h04,
		ST_RUN_ISP    = 5'h08,
		ST_RUN_TEST   = 5'h10
	} boot_state_type;

endpackage : sysconf_pkg

// ---- logic/clk_ctl_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface clk_ctl_if;
	logic cpu_oe;
	logic half_en;
	logic slow_small_en;
	logic slow_large_en;

	modport ctl (
		output cpu_oe,
		output half_en,
		output slow_small_en,
		output slow_large_en
	);

	modport pins (
		input  cpu_oe,
		input  half_en,
		input  slow_small_en,
		input  slow_large_en
	);
endinterface : clk_ctl_if

`default_nettype wire

// ---- logic/strap_capture.sv ----
`timescale 1ns/10ps
`default_nettype none

module strap_capture
	import sysconf_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       strap_low_i,
	input  wire logic       strap_high_i,
	output logic            pullup_en_o,
	output logic [1:0]      captured_o
);

	logic       pullup_q;
	logic [1:0] strap_q;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pullup_q <= 1'b1;
		end else begin
			pullup_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			strap_q <= {strap_high_i, strap_low_i};
		end
	end

	assign pullup_en_o = pullup_q;
	assign captured_o  = strap_q;

endmodule : strap_capture

`default_nettype wire

// ---- logic/clock_pins.sv ----
`timescale 1ns/10ps
`default_nettype none

module clock_pins #(
	parameter int CPU_DIV = 2
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic slow_clk_i,
	clk_ctl_if.pins   ctl,
	output logic      cpu_pin_o,
	output logic      cpu_oe_o,
	output logic      half_pin_o,
	output logic      half_oe_o,
	output logic      slow_small_o,
	output logic      slow_small_oe_o,
	output logic      slow_large_o,
	output logic      slow_large_oe_o
);

	localparam int CNT_W = $clog2(CPU_DIV + 1);

	generate
		if (CPU_DIV < 1) begin : g_bad_div
			$error("CPU_DIV must be at least 1");
		end
	endgenerate

	logic [CNT_W-1:0] div_q;
	logic             tick;
	logic             cpu_q;
	logic             half_q;

	assign tick = (div_q == CNT_W'(CPU_DIV - 1));

	always_ff @(posedge clk_i) begin
		if (!rstn_i || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cpu_q  <= 1'b0;
			half_q <= 1'b0;
		end else if (tick) begin
			cpu_q <= ~cpu_q;
			if (cpu_q) begin
				half_q <= ~half_q;
			end
		end
	end

	assign cpu_pin_o       = cpu_q;
	assign cpu_oe_o        = ctl.cpu_oe;
	assign half_pin_o      = half_q;
	assign half_oe_o       = ctl.half_en & ~ctl.cpu_oe;
	assign slow_small_o    = slow_clk_i;
	assign slow_small_oe_o = ctl.slow_small_en;
	assign slow_large_o    = slow_clk_i;
	assign slow_large_oe_o = ctl.slow_large_en;

endmodule : clock_pins

`default_nettype wire

// ---- verif/strap_board.sv ----
`timescale 1ns/10ps
`default_nettype none

module strap_board (
	input  wire logic clk_i,
	input  wire logic pullup_en_i,
	input  wire logic drive_low_i,
	input  wire logic drive_high_i,
	output logic      strap_low_o,
	output logic      strap_high_o
);
	// ------------------------------------------------------------
	// Strap wires
	// ------------------------------------------------------------
	logic toggle_q;

	initial toggle_q = 1'b0;

	// Released and unpulled lines wander every cycle
	always @(posedge clk_i) begin
		toggle_q <= ~toggle_q;
	end

	always_comb begin
		strap_low_o  = drive_low_i  ? 1'b0 : (pullup_en_i ? 1'b1 : toggle_q);
		strap_high_o = drive_high_i ? 1'b0 : (pullup_en_i ? 1'b1 : ~toggle_q);
	end
endmodule : strap_board

`default_nettype wire

// ---- verif/system_config_mode_select_bench.sv ----
`timescale 1ns/10ps
`default_nettype none

module system_config_mode_select_bench
	import sysconf_pkg::*;
;
	typedef struct packed {logic rd; logic [31:0] data; logic err;} note_type;
	logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rnd;
	logic [3:0]  pstrb_i;
	logic        mode_strap_low_i, mode_strap_high_i, strap_pullup_en_o;
	logic        program_memory_empty_i, program_busy_i, slow_clk_i, ee_req_i, ee_ack_o;
	logic        cpu_clock_pin_o, cpu_clock_pin_oe_o, half_rate_clock_pin_o;
	logic        half_rate_clock_pin_oe_o, slow_clock_pin_small_o, slow_clock_pin_small_oe_o;
	logic        slow_clock_pin_large_o, slow_clock_pin_large_oe_o, ee_wait_states_o;
	logic        cpu_start_o, test_mode_o, in_system_programming_mode_o;
	logic        internal_memory_run_mode_o, pc, ph;
	logic [15:0] cpu_start_addr_o;
	logic [1:0]  sel_q;
	logic [2:0]  slow_cnt;
	logic [7:0]  v, m;
	note_type    q[$];
	note_type    note;
	int          error_cnt, compares, i, cr, hr;
	logic [1:0]  sels [5] = '{2'b00, 2'b00, 2'b01, 2'b10, 2'b11};
	logic        emps [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

	sysconf_top #(.CPU_DIV(1)) uut (
		.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.mode_strap_low_i(mode_strap_low_i), .mode_strap_high_i(mode_strap_high_i),
		.strap_pullup_en_o(strap_pullup_en_o), .program_memory_empty_i(program_memory_empty_i),
		.program_busy_i(program_busy_i), .slow_clk_i(slow_clk_i),
		.cpu_clock_pin_o(cpu_clock_pin_o), .cpu_clock_pin_oe_o(cpu_clock_pin_oe_o),
		.half_rate_clock_pin_o(half_rate_clock_pin_o),
		.half_rate_clock_pin_oe_o(half_rate_clock_pin_oe_o),
		.slow_clock_pin_small_o(slow_clock_pin_small_o),
		.slow_clock_pin_small_oe_o(slow_clock_pin_small_oe_o),
		.slow_clock_pin_large_o(slow_clock_pin_large_o),
		.slow_clock_pin_large_oe_o(slow_clock_pin_large_oe_o),
		.ee_req_i(ee_req_i), .ee_ack_o(ee_ack_o), .ee_wait_states_o(ee_wait_states_o),
		.cpu_start_o(cpu_start_o), .cpu_start_addr_o(cpu_start_addr_o),
		.test_mode_o(test_mode_o), .in_system_programming_mode_o(in_system_programming_mode_o),
		.internal_memory_run_mode_o(internal_memory_run_mode_o)
	);

	strap_board board (
		.clk_i(clk_i), .pullup_en_i(strap_pullup_en_o), .drive_low_i(sel_q[0]),
		.drive_high_i(sel_q[1]), .strap_low_o(mode_strap_low_i),
		.strap_high_o(mode_strap_high_i)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report;
		$display("Checks %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [31:0] exp, input logic err);
		int n;
		q.push_back('{!w, exp, err});
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (pready_o !== 1'b1) begin
			error_cnt++;
			final_report();
		end
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask : apb

	task automatic do_reset(input logic [1:0] sel, input logic empty);
		logic        hi, lo, seen;
		logic [15:0] addr;
		int          n;
		hi = !sel[1];
		lo = !sel[0];
		seen = 1'b0;
		addr = 16'h0000;
		rstn_i <= 1'b0;
		sel_q <= sel;
		program_memory_empty_i <= empty;
		@(posedge clk_i);
		#1;
		check("pullup_rst", strap_pullup_en_o, 1'b1);
		@(posedge clk_i);
		rstn_i <= 1'b1;
		for (n = 0; n < 6; n++) begin
			@(posedge clk_i);
			#1;
			if (cpu_start_o === 1'b1) begin
				seen = 1'b1;
				addr = cpu_start_addr_o;
			end
		end
		check("pullup_run", strap_pullup_en_o, 1'b0);
		check("test_mode", test_mode_o, !hi);
		check("isp_mode", in_system_programming_mode_o, hi & (!lo | empty));
		check("ire_mode", internal_memory_run_mode_o, hi & lo & !empty);
		check("start_seen", seen, hi);
		check("start_addr", addr, !hi ? 16'h0 : (lo & !empty) ? IRE_START_ADDR : BOOT_ROM_ADDR);
		rnd = lfsr(rnd);
		@(posedge clk_i);
		sel_q <= ~sel;
		program_busy_i <= rnd[0];
		@(posedge clk_i);
		apb(1'b0, STATUS_OFFSET, 32'h0, {28'h0, program_busy_i, 1'b0, hi, lo}, 1'b0);
	endtask : do_reset

	task automatic ee_latency(input logic fast);
		int n;
		apb(1'b1, CFG_OFFSET, fast ? 32'h08 : 32'h00, 32'h0, 1'b0);
		ee_req_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			ee_req_i <= 1'b0;
			n++;
			#1;
		end while (ee_ack_o !== 1'b1 && n < 8);
		check("ee_latency", n, fast ? 1 : 2);
		@(posedge clk_i);
	endtask : ee_latency

	// ------------------------------------------------------------
	// Clock, slow clock, monitor, watchdog
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		slow_cnt   <= slow_cnt + 3'h1;
		slow_clk_i <= slow_cnt[2];
	end

	always @(posedge clk_i) begin
		if (psel_i && penable_i && pready_o === 1'b1) begin
			if (q.size() == 0) begin
				error_cnt++;
				$display("Error apb_note expected queued seen none");
			end else begin
				note = q.pop_front();
				if (note.rd) check("prdata", prdata_o, note.data);
				check("pslverr", pslverr_o, note.err);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		final_report();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rstn_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		pstrb_i = 4'hF;
		sel_q = 2'b00;
		program_memory_empty_i = 1'b0;
		program_busy_i = 1'b0;
		slow_clk_i = 1'b0;
		slow_cnt = 3'h0;
		ee_req_i = 1'b0;
		rnd = 32'h4C162F4F;
		error_cnt = 0;
		compares = 0;
		for (i = 0; i < 5; i++) do_reset(sels[i], emps[i]);
		do_reset(2'b00, 1'b0);
		apb(1'b0, CFG_OFFSET, 32'h0, 32'h0, 1'b0);
		for (i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			v = (i == 0) ? 8'h22 : (i == 1) ? 8'h20 : (i == 2) ? 8'h3E : rnd[7:0] & 8'h3E;
			m = v & 8'h3E;
			apb(1'b1, CFG_OFFSET, {24'h0, v}, 32'h0, 1'b0);
			apb(1'b0, CFG_OFFSET, 32'h0, {24'h0, m}, 1'b0);
			#1;
			check("cpu_oe", cpu_clock_pin_oe_o, m[1]);
			check("half_oe", half_rate_clock_pin_oe_o, m[5] & !m[1]);
			check("small_oe", slow_clock_pin_small_oe_o, m[2]);
			check("large_oe", slow_clock_pin_large_oe_o, m[4]);
			check("slow_pins", {slow_clock_pin_small_o, slow_clock_pin_large_o}, {2{slow_clk_i}});
			check("ee_wait", ee_wait_states_o, m[3] ? EE_WAIT_FAST : EE_WAIT_SLOW);
			@(posedge clk_i);
		end
		apb(1'b1, CFG_OFFSET, 32'h20, 32'h0, 1'b0);
		cr = 0;
		hr = 0;
		pc = cpu_clock_pin_o;
		ph = half_rate_clock_pin_o;
		repeat (64) begin
			@(posedge clk_i);
			#1;
			if (cpu_clock_pin_o && !pc) cr++;
			if (half_rate_clock_pin_o && !ph) hr++;
			pc = cpu_clock_pin_o;
			ph = half_rate_clock_pin_o;
		end
		check("cpu_rate", cr >= 31 && cr <= 33, 1'b1);
		check("half_rate", hr * 2 >= cr - 2 && hr * 2 <= cr + 2, 1'b1);
		@(posedge clk_i);
		ee_latency(1'b1);
		ee_latency(1'b0);
		apb(1'b1, CFG_OFFSET, 32'h16, 32'h0, 1'b0);
		apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h00C, 32'hFF, 32'h0, 1'b1);
		apb(1'b1, STATUS_OFFSET, 32'h3, 32'h0, 1'b1);
		// Byte 0 strobe low leaves the configuration untouched
		pstrb_i <= 4'hE;
		apb(1'b1, CFG_OFFSET, 32'h02, 32'h0, 1'b0);
		pstrb_i <= 4'hF;
		apb(1'b0, CFG_OFFSET, 32'h0, 32'h16, 1'b0);
		final_report();
	end
endmodule : system_config_mode_select_bench

`default_nettype wire
